// ===== hdl/pixel_mux_mode_select.sv
// pixel-port multiplexer: mode-code decode, bus-load capture and per-pixel unpacking
// assumes pixel_load_clock_i is a one-cycle enable synchronous to mclk_i, data valid with it
//
// What this block does
// - each load pulse under a defined mode code with the buffer ready takes one bus word yielding as many pixels as the multiplex ratio.
// - only the mode's bit-plane count of bits forms each pixel's colour; the rest forms the overlay in 24-bit, 5-5-5 and 4-4-4 modes, else is ignored.
// - mode code writes never change the reference clock divide ratio.
// - second control code bit 7 enables the vga pixel port; zero disables it.
// - reset gives vga pass-through, vga enabled, both palette selects set.
// - direct-colour red, green and blue fields under 8 bits are msb-justified with zero low bits; overlay is lsb-justified.
module pixel_mux_mode_select
    import pix_mode_pkg::*;
(
    // clock and reset
    input  wire logic                             mclk_i,
    input  wire logic                             rst_n_i,
    // control writes
    input  wire logic [pix_mode_pkg::CODE_W-1:0]  ctrl_wdata_i,
    input  wire logic                             mux1_wr_i,
    input  wire logic                             mux2_wr_i,
    input  wire logic                             clk_sel_wr_i,
    input  wire logic                             palette_sel_wr_i,
    // pixel bus from frame buffer
    input  wire logic                             pixel_load_clock_i,
    input  wire logic [pix_mode_pkg::BUS_W-1:0]   pix_bus_i,
    input  wire logic [pix_mode_pkg::VGA_W-1:0]   vga_bus_i,
    output logic                                  load_ready_o,
    output logic                                  load_lost_o,
    // unpacked pixel stream
    output pix_mode_pkg::pixel_s                  pix_o,
    output logic                                  pix_valid_o,
    input  wire logic                             pix_ready_i,
    // mode and control state
    output pix_mode_pkg::mode_s                   mode_o,
    output logic [pix_mode_pkg::CODE_W-1:0]       mux1_code_o,
    output logic [pix_mode_pkg::CODE_W-1:0]       mux2_code_o,
    output logic                                  vga_port_en_o,
    output logic [pix_mode_pkg::REFDIV_W-1:0]     refclk_div_o,
    output logic                                  window_palette_select_bit_o,
    output logic                                  key_palette_select_bit_o
);
    import pix_mode_pkg::*;

    typedef struct packed {
        logic [CODE_W-1:0]   mux1;
        logic [CODE_W-1:0]   mux2;
        logic [REFDIV_W-1:0] refdiv;
        logic                win_sel;
        logic                key_sel;
        mode_s               mode;
        load_s               word;
        logic                busy;
        logic [4:0]          k;
        pixel_s              pix;
        logic                pix_valid;
        logic                lost;
    } st_s;

    st_s   s_ff;
    st_s   nxt_s;
    logic  push_valid;
    logic  buf_ready;
    logic  buf_valid;
    logic  buf_take;
    load_s buf_data;
    logic  emit;
    logic  last;

    // decode of the two control codes into mode fields
    function automatic mode_s decode_mode(input logic [CODE_W-1:0] c1, input logic [CODE_W-1:0] c2);
        mode_s      m;
        logic [6:0] c7;
        c7        = c2[6:0];
        m         = MODE_RESET;
        m.kind    = MODE_NONE;
        m.vga_en  = c2[VGA_EN_BIT];
        m.ov_bits = OV_NONE;
        m.bus_width = c7[0] ? BUS_32 : BUS_16;
        m.ratio   = c7[0] ? RATIO_2 : RATIO_1;
        if (c1 == MUX1_PSEUDO && c2 == MUX2_VGA) begin
            m = MODE_RESET;
        end else if (c1 == MUX1_PSEUDO) begin
            // pseudo colour: bpp = 1<<c[4:3], width = 4<<c[1:0]
            if (c7[6:5] == 2'h0 && !c7[2] && c7 != MUX2_PSEUDO_BAD) begin
                m.kind      = MODE_PSEUDO;
                m.bpp_log   = c7[4:3];
                m.bpp       = 6'(1) << c7[4:3];
                m.bus_width = BUS_PSEUDO_MIN << c7[1:0];
                m.ratio     = m.bus_width >> c7[4:3];
            end
        end else if ((c1 == MUX1_D24_ORGB || c1 == MUX1_D24_BGRO) && c7 == MUX2_D24) begin
            m.kind      = (c1 == MUX1_D24_ORGB) ? MODE_D24_ORGB : MODE_D24_BGRO;
            m.bpp       = BPP_24;
            m.bus_width = BUS_32;
            m.ratio     = RATIO_1;
            m.ov_bits   = OV_8;
        end else if (c7 == MUX2_D16_NARROW || c7 == MUX2_D16_WIDE) begin
            case (c1)
                MUX1_D565: begin
                    m.kind = MODE_D565;
                    m.bpp  = BPP_16;
                end
                MUX1_D555: begin
                    m.kind    = MODE_D555;
                    m.bpp     = BPP_15;
                    m.ov_bits = OV_1;
                end
                MUX1_D664: begin
                    m.kind = MODE_D664;
                    m.bpp  = BPP_16;
                end
                default: m.kind = MODE_NONE;
            endcase
        end else if (c1 == MUX1_D444 && (c7 == MUX2_D444_NARROW || c7 == MUX2_D444_WIDE)) begin
            m.kind    = MODE_D444;
            m.bpp     = BPP_12;
            m.ov_bits = OV_4;
        end
        return m;
    endfunction

    // pick pixel k out of a bus load
    function automatic pixel_s unpack(input load_s w, input logic [4:0] k);
        pixel_s             p;
        logic [BUS_W-1:0]   sh;
        logic [15:0]        h;
        sh = w.bus >> (8'(k) << w.mode.bpp_log);
        h  = k[0] ? w.bus[31:16] : w.bus[15:0];
        p  = '0;
        p.direct = 1'b1;
        case (w.mode.kind)
            MODE_VGA: begin
                p.direct = 1'b0;
                p.index  = w.mode.vga_en ? w.vga : '0;
            end
            MODE_PSEUDO: begin
                p.direct = 1'b0;
                p.index  = sh[7:0] & ~(8'hFF << w.mode.bpp);
            end
            MODE_D24_ORGB: begin
                p.overlay = w.bus[31:24];
                p.red     = w.bus[23:16];
                p.green   = w.bus[15:8];
                p.blue    = w.bus[7:0];
            end
            MODE_D24_BGRO: begin
                p.blue    = w.bus[31:24];
                p.green   = w.bus[23:16];
                p.red     = w.bus[15:8];
                p.overlay = w.bus[7:0];
            end
            MODE_D565: begin
                p.red   = {h[15:11], 3'h0};
                p.green = {h[10:5], 2'h0};
                p.blue  = {h[4:0], 3'h0};
            end
            MODE_D555: begin
                p.overlay = {7'h00, h[15]};
                p.red     = {h[14:10], 3'h0};
                p.green   = {h[9:5], 3'h0};
                p.blue    = {h[4:0], 3'h0};
            end
            MODE_D664: begin
                p.red   = {h[15:10], 2'h0};
                p.green = {h[9:4], 2'h0};
                p.blue  = {h[3:0], 4'h0};
            end
            MODE_D444: begin
                p.overlay = {4'h0, h[15:12]};
                p.red     = {h[11:8], 4'h0};
                p.green   = {h[7:4], 4'h0};
                p.blue    = {h[3:0], 4'h0};
            end
            default: p = '0;
        endcase
        return p;
    endfunction

    // two-entry buffer holds loads while the pixel receiver stalls
    load_buffer #(
        .WIDTH ($bits(load_s))
    ) u_load_buffer (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (buf_ready),
        .in_data_i   ({s_ff.mode, pix_bus_i, vga_bus_i}),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_take),
        .out_data_o  (buf_data)
    );

    // control writes, load capture and pixel unpacking
    always_comb begin
        nxt_s = s_ff;
        if (mux1_wr_i) begin
            nxt_s.mux1 = ctrl_wdata_i;
        end
        if (mux2_wr_i) begin
            nxt_s.mux2 = ctrl_wdata_i;
        end
        if (clk_sel_wr_i) begin
            nxt_s.refdiv = ctrl_wdata_i[REFDIV_W-1:0];
        end
        if (palette_sel_wr_i) begin
            nxt_s.win_sel = ctrl_wdata_i[0];
            nxt_s.key_sel = ctrl_wdata_i[1];
        end
        nxt_s.mode = decode_mode(nxt_s.mux1, nxt_s.mux2);
        // one word per load pulse; undefined codes take nothing
        push_valid = pixel_load_clock_i && (s_ff.mode.kind != MODE_NONE);
        nxt_s.lost = push_valid && !buf_ready;
        if (s_ff.pix_valid && pix_ready_i) begin
            nxt_s.pix_valid = 1'b0;
        end
        emit = s_ff.busy && (!s_ff.pix_valid || pix_ready_i);
        last = ({1'b0, s_ff.k} == s_ff.word.mode.ratio - 6'h01);
        if (emit) begin
            nxt_s.pix       = unpack(s_ff.word, s_ff.k);
            nxt_s.pix_valid = 1'b1;
            nxt_s.k         = s_ff.k + 5'h01;
            if (last) begin
                nxt_s.busy = 1'b0;
            end
        end
        buf_take = buf_valid && (!s_ff.busy || (emit && last));
        if (buf_take) begin
            nxt_s.word = buf_data;
            nxt_s.busy = 1'b1;
            nxt_s.k    = 5'h00;
        end
    end

    // state register; reset is vga pass-through
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff           <= '0;
            s_ff.mux1      <= MUX1_RESET;
            s_ff.mux2      <= MUX2_RESET;
            s_ff.refdiv    <= REFDIV_RESET;
            s_ff.win_sel   <= PAL_SEL_RESET;
            s_ff.key_sel   <= PAL_SEL_RESET;
            s_ff.mode      <= MODE_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from state flops
    assign load_ready_o                = buf_ready;
    assign load_lost_o                 = s_ff.lost;
    assign pix_o                       = s_ff.pix;
    assign pix_valid_o                 = s_ff.pix_valid;
    assign mode_o                      = s_ff.mode;
    assign mux1_code_o                 = s_ff.mux1;
    assign mux2_code_o                 = s_ff.mux2;
    assign vga_port_en_o               = s_ff.mux2[VGA_EN_BIT];
    assign refclk_div_o                = s_ff.refdiv;
    assign window_palette_select_bit_o = s_ff.win_sel;
    assign key_palette_select_bit_o    = s_ff.key_sel;

endmodule

// ===== include/pix_mode_pkg.sv
// pixel-port multiplexer mode package: control codes, decoded mode fields, carriers
// assumes a single 125 MHz clock domain; shared by the mode/unpack block, its checker and the bench
package pix_mode_pkg;

    // bus and field widths
    localparam int BUS_W    = 32;
    localparam int VGA_W    = 8;
    localparam int CODE_W   = 8;
    localparam int COLOR_W  = 8;
    localparam int REFDIV_W = 3;
    localparam int VGA_EN_BIT = 7;

    // control register reset values (vga pass-through)
    localparam logic [CODE_W-1:0]   MUX1_RESET   = 8'h80;
    localparam logic [CODE_W-1:0]   MUX2_RESET   = 8'h98;
    localparam logic [REFDIV_W-1:0] REFDIV_RESET = 3'h0;
    localparam logic                PAL_SEL_RESET = 1'b1;

    // first control code values
    localparam logic [CODE_W-1:0] MUX1_PSEUDO   = 8'h80;
    localparam logic [CODE_W-1:0] MUX1_D24_ORGB = 8'h06;
    localparam logic [CODE_W-1:0] MUX1_D24_BGRO = 8'h07;
    localparam logic [CODE_W-1:0] MUX1_D565     = 8'h05;
    localparam logic [CODE_W-1:0] MUX1_D555     = 8'h04;
    localparam logic [CODE_W-1:0] MUX1_D664     = 8'h03;
    localparam logic [CODE_W-1:0] MUX1_D444     = 8'h01;

    // second control code values, vga enable bit masked off except in MUX2_VGA
    localparam logic [CODE_W-1:0] MUX2_VGA       = 8'h98;
    localparam logic [6:0]        MUX2_D24       = 7'h1B;
    localparam logic [6:0]        MUX2_D16_NARROW = 7'h02;
    localparam logic [6:0]        MUX2_D16_WIDE  = 7'h03;
    localparam logic [6:0]        MUX2_D444_NARROW = 7'h12;
    localparam logic [6:0]        MUX2_D444_WIDE = 7'h13;
    localparam logic [6:0]        MUX2_PSEUDO_BAD = 7'h18;

    // decoded field values
    localparam logic [5:0] BPP_24     = 6'h18;
    localparam logic [5:0] BPP_16     = 6'h10;
    localparam logic [5:0] BPP_15     = 6'h0F;
    localparam logic [5:0] BPP_12     = 6'h0C;
    localparam logic [5:0] BPP_8      = 6'h08;
    localparam logic [5:0] BUS_8      = 6'h08;
    localparam logic [5:0] BUS_16     = 6'h10;
    localparam logic [5:0] BUS_32     = 6'h20;
    localparam logic [5:0] BUS_PSEUDO_MIN = 6'h04;
    localparam logic [5:0] RATIO_1    = 6'h01;
    localparam logic [5:0] RATIO_2    = 6'h02;
    localparam logic [3:0] OV_NONE    = 4'h0;
    localparam logic [3:0] OV_1       = 4'h1;
    localparam logic [3:0] OV_4       = 4'h4;
    localparam logic [3:0] OV_8       = 4'h8;
    localparam logic [1:0] BPP_LOG_8  = 2'h3;

    typedef enum logic [3:0] {
        MODE_VGA, MODE_PSEUDO, MODE_D24_ORGB, MODE_D24_BGRO,
        MODE_D565, MODE_D555, MODE_D664, MODE_D444, MODE_NONE
    } mode_e;

    // decoded multiplexer mode
    typedef struct packed {
        mode_e      kind;
        logic       vga_en;
        logic [1:0] bpp_log;
        logic [5:0] bpp;
        logic [5:0] bus_width;
        logic [5:0] ratio;
        logic [3:0] ov_bits;
    } mode_s;

    localparam mode_s MODE_RESET = '{kind: MODE_VGA, vga_en: 1'b1, bpp_log: BPP_LOG_8, bpp: BPP_8,
                                     bus_width: BUS_8, ratio: RATIO_1, ov_bits: OV_NONE};

    // one bus load with the mode it was taken under
    typedef struct packed {
        mode_s             mode;
        logic [BUS_W-1:0]  bus;
        logic [VGA_W-1:0]  vga;
    } load_s;

    // one unpacked pixel
    typedef struct packed {
        logic               direct;
        logic [COLOR_W-1:0] index;
        logic [COLOR_W-1:0] red;
        logic [COLOR_W-1:0] green;
        logic [COLOR_W-1:0] blue;
        logic [COLOR_W-1:0] overlay;
    } pixel_s;

endpackage

// ===== hdl/load_buffer.sv
// two-entry valid/ready buffer between bus-load capture and pixel unpacking
// assumes one clock; in_ready_o is a flop, out side is first-word fall-through
module load_buffer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wp;
        logic                  rp;
        logic [1:0]            cnt;
        logic                  in_ready;
    } buf_st_s;

    buf_st_s s_ff;
    buf_st_s nxt_s;
    logic    push;
    logic    pop;

    // pointer and count update; ready drops only when both entries hold data
    always_comb begin
        nxt_s = s_ff;
        push  = in_valid_i && s_ff.in_ready;
        pop   = out_ready_i && (s_ff.cnt != 2'h0);
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data_i;
            nxt_s.wp           = ~s_ff.wp;
        end
        if (pop) begin
            nxt_s.rp = ~s_ff.rp;
        end
        nxt_s.cnt      = s_ff.cnt + {1'b0, push} - {1'b0, pop};
        nxt_s.in_ready = (nxt_s.cnt != 2'h2);
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '{mem: '0, wp: 1'b0, rp: 1'b0, cnt: 2'h0, in_ready: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign in_ready_o  = s_ff.in_ready;
    assign out_valid_o = (s_ff.cnt != 2'h0);
    assign out_data_o  = s_ff.mem[s_ff.rp];

endmodule

// ===== tb/mux_mode_asserts.sv
// checker for the pixel multiplexer: code writes, divide ratio, load and pixel flow
// assumes binding to pixel_mux_mode_select; one clock, active-low async reset
module mux_mode_asserts
    import pix_mode_pkg::*;
(
    // clock and reset
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    // control writes
    input wire logic [CODE_W-1:0]       ctrl_wdata_i,
    input wire logic                    mux2_wr_i,
    input wire logic                    clk_sel_wr_i,
    // load side
    input wire logic                    pixel_load_clock_i,
    input wire logic                    load_ready_o,
    input wire logic                    load_lost_o,
    // pixel side
    input wire pix_mode_pkg::pixel_s    pix_o,
    input wire logic                    pix_valid_o,
    input wire logic                    pix_ready_i,
    // mode state
    input wire pix_mode_pkg::mode_s     mode_o,
    input wire logic [CODE_W-1:0]       mux1_code_o,
    input wire logic [CODE_W-1:0]       mux2_code_o,
    input wire logic                    vga_port_en_o,
    input wire logic [REFDIV_W-1:0]     refclk_div_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // a load taken into an empty pipe, then its first pixel
    sequence load_taken;
        pixel_load_clock_i && load_ready_o && mode_o.kind != MODE_NONE && !pix_valid_o && !$past(pixel_load_clock_i);
    endsequence
    // buffer takes it, unpacker takes it, pixel register shows it: seen high at the third edge
    sequence pixel_shown;
        ##3 pix_valid_o;
    endsequence

    first_pixel_a: assert property (load_taken |-> pixel_shown) else $error("no pixel after load");
    lost_flag_a: assert property (pixel_load_clock_i && !load_ready_o && mode_o.kind != MODE_NONE |=> load_lost_o)
        else $error("dropped load not flagged");
    lost_cause_a: assert property (load_lost_o |-> $past(pixel_load_clock_i && !load_ready_o))
        else $error("lost flag without refused load");
    pix_hold_a: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_o))
        else $error("pixel changed while stalled");
    refdiv_hold_a: assert property (!clk_sel_wr_i |=> $stable(refclk_div_o))
        else $error("divide ratio moved without its write");
    refdiv_load_a: assert property (clk_sel_wr_i |=> refclk_div_o == $past(ctrl_wdata_i[2:0]))
        else $error("divide ratio not loaded");
    vga_bit_a: assert property (mux2_wr_i |=> vga_port_en_o == $past(ctrl_wdata_i[VGA_EN_BIT]) && mux2_code_o == $past(ctrl_wdata_i))
        else $error("vga enable not from bit 7");
    nibble_mode_a: assert property (mux1_code_o == MUX1_PSEUDO && mux2_code_o[6:0] == 7'h13
        |-> mode_o.bpp == 6'h04 && mode_o.ratio == 6'h08 && mode_o.bus_width == BUS_32)
        else $error("4-bit pseudo decode wrong");
    d565_mode_a: assert property (mux1_code_o == MUX1_D565 && mux2_code_o[6:0] == MUX2_D16_WIDE
        |-> mode_o.bpp == BPP_16 && mode_o.ratio == RATIO_2) else $error("5-6-5 decode wrong");
    d24_mode_a: assert property (mux1_code_o == MUX1_D24_ORGB && mux2_code_o[6:0] == MUX2_D24
        |-> mode_o.bpp == BPP_24 && mode_o.ratio == RATIO_1 && mode_o.ov_bits == OV_8)
        else $error("24-bit decode wrong");
endmodule

// ===== tb/frame_source.sv
// frame-buffer model: offers one pixel-bus word per load pulse
// assumes send is entered one time unit after a rising clock edge
module frame_source (
    // clock
    input  wire logic   mclk_i,
    // handshake and bus
    input  wire logic   load_ready_i,
    output logic        pixel_load_clock_o,
    output logic [31:0] pix_bus_o,
    output logic [7:0]  vga_bus_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle lines at time zero
    initial begin
        pixel_load_clock_o = 1'b0;
        pix_bus_o          = 32'h0;
        vga_bus_o          = 8'h00;
    end

    // offer a word; hold keeps the pulse up for a back-to-back follower
    task automatic send(input logic [31:0] w, input logic [7:0] v, input bit force_go, input bit hold);
        while (!force_go && !load_ready_i) begin
            pixel_load_clock_o = 1'b0;
            @(posedge mclk_i);
            #1;
        end
        pixel_load_clock_o = 1'b1;
        pix_bus_o          = w;
        vga_bus_o          = v;
        @(posedge mclk_i);
        #1;
        // released bus shows the inverse so stale data never looks valid
        if (!hold) begin
            pixel_load_clock_o = 1'b0;
            pix_bus_o          = ~w;
            vga_bus_o          = ~v;
        end
    endtask
endmodule

// ===== tb/testbench.sv
// top bench for the pixel multiplexer with a frame-buffer source model
// assumes the package is compiled first; one 125 MHz clock
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pix_mode_pkg::*;

    // clock, reset, control and pixel side
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [3:0]  wr_stb = 4'h0;
    logic        pix_ready = 1'b1;
    logic        ld_clk, ld_ready, ld_lost, pix_valid, vga_en, win_sel, key_sel;
    logic [31:0] pbus;
    logic [7:0]  vbus, m1, m2;
    logic [2:0]  refdiv;
    pixel_s      pix;
    mode_s       mode;
    pixel_s      q[$];
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;

    always #4 mclk_i = ~mclk_i;

    pixel_mux_mode_select u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ctrl_wdata_i(wdata),
        .mux1_wr_i(wr_stb[0]), .mux2_wr_i(wr_stb[1]), .clk_sel_wr_i(wr_stb[2]), .palette_sel_wr_i(wr_stb[3]),
        .pixel_load_clock_i(ld_clk), .pix_bus_i(pbus), .vga_bus_i(vbus), .load_ready_o(ld_ready),
        .load_lost_o(ld_lost), .pix_o(pix), .pix_valid_o(pix_valid), .pix_ready_i(pix_ready),
        .mode_o(mode), .mux1_code_o(m1), .mux2_code_o(m2), .vga_port_en_o(vga_en), .refclk_div_o(refdiv),
        .window_palette_select_bit_o(win_sel), .key_palette_select_bit_o(key_sel));

    frame_source u_src (.mclk_i(mclk_i), .load_ready_i(ld_ready), .pixel_load_clock_o(ld_clk),
        .pix_bus_o(pbus), .vga_bus_o(vbus));

    // collect every pixel the receiver takes; cut a hang short
    always @(posedge mclk_i) begin
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            q.push_back(pix);
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask

    // one-cycle control strobe: 0 mux1, 1 mux2, 2 divide ratio, 3 palette selects
    task automatic wr(input int which, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        wdata = d;
        wr_stb[which] = 1'b1;
        @(posedge mclk_i);
        #1;
        wr_stb = 4'h0;
    endtask

    // wait for the pixels, then compare index or packed colour of each
    task automatic expect_pix(input logic [31:0] exp[$], input bit direct);
        int k;
        k = 0;
        while (q.size() < exp.size() && k < 100) begin
            @(posedge mclk_i);
            k++;
        end
        repeat (6) @(posedge mclk_i);
        #1;
        check(q.size(), exp.size(), "pixel count");
        foreach (exp[i]) begin
            if (i < q.size()) begin
                check(direct ? {q[i].overlay, q[i].red, q[i].green, q[i].blue} : {24'h0, q[i].index}, exp[i], "pixel");
                check(q[i].direct, direct, "pixel kind");
            end
        end
        q.delete();
    endtask

    // reset state, then palette select writes
    task automatic t_reset();
        check(m1, 8'h80, "mux1 reset");
        check(m2, 8'h98, "mux2 reset");
        check({vga_en, win_sel, key_sel}, 3'b111, "enables");
        check(refdiv, 3'h0, "divide reset");
        check(mode.ratio, RATIO_1, "vga ratio");
        check(ld_ready, 1'b1, "ready");
        wr(3, 8'h01);
        check({win_sel, key_sel}, 2'b10, "palette selects");
    endtask

    // vga bytes one per load; a full buffer refuses and flags the lost word
    task automatic t_vga_stall();
        logic [31:0] exp[$];
        int n;
        pix_ready = 1'b0;
        n = 0;
        while (ld_ready === 1'b1 && n < 6) begin
            u_src.send(32'h0, 8'hA0 + n[7:0], 1'b0, 1'b1);
            exp.push_back(32'hA0 + n);
            n++;
        end
        check(ld_ready, 1'b0, "buffer full");
        u_src.send(32'h0, 8'h5A, 1'b1, 1'b0);
        check(ld_lost, 1'b1, "lost flag");
        pix_ready = 1'b1;
        expect_pix(exp, 1'b0);
    endtask

    // 8-bit pseudo colour, four pixels a load; divide ratio survives mode writes
    task automatic t_pseudo8();
        wr(2, 8'h02);
        wr(1, 8'h1B);
        check(refdiv, 3'h2, "divide kept");
        check(vga_en, 1'b0, "vga off");
        check(mode.ratio, 6'h04, "ratio");
        u_src.send(32'h44332211, 8'h00, 1'b0, 1'b0);
        expect_pix('{32'h11, 32'h22, 32'h33, 32'h44}, 1'b0);
    endtask

    // 4-bit pseudo colour, eight pixels a load, lowest nibble first
    task automatic t_pseudo4();
        wr(1, 8'h13);
        u_src.send(32'h87654321, 8'h00, 1'b0, 1'b0);
        expect_pix('{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7, 32'h8}, 1'b0);
    endtask

    // 5-6-5 direct colour, two pixels a load, fields msb-justified
    task automatic t_d565();
        wr(0, 8'h05);
        wr(1, 8'h03);
        check(refdiv, 3'h2, "divide kept");
        u_src.send(32'h07E0F801, 8'h00, 1'b0, 1'b0);
        expect_pix('{32'hF80008, 32'h00FC00}, 1'b1);
    endtask

    // 4-4-4 direct colour with 4-bit overlay, two pixels a load, overlay lsb-justified
    task automatic t_d444();
        wr(0, 8'h01);
        wr(1, 8'h13);
        check(mode.bpp, BPP_12, "444 bpp");
        u_src.send(32'h1234ABCD, 8'h00, 1'b0, 1'b0);
        expect_pix('{32'h0AB0C0D0, 32'h01203040}, 1'b1);
    endtask

    // 24-bit direct colour with the vga port left on, then back to pass-through
    task automatic t_d24();
        wr(0, 8'h06);
        wr(1, 8'h9B);
        check(vga_en, 1'b1, "vga on");
        check(mode.bpp, BPP_24, "bpp");
        u_src.send(32'hAA112233, 8'h00, 1'b0, 1'b0);
        expect_pix('{32'hAA112233}, 1'b1);
        wr(0, 8'h80);
        wr(1, 8'h98);
        check(mode.kind, MODE_VGA, "vga again");
    endtask

    task automatic end_sim();
        $display("mismatches %0d of %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        t_reset();
        t_vga_stall();
        t_pseudo8();
        t_pseudo4();
        t_d565();
        t_d444();
        t_d24();
        end_sim();
    end
endmodule

bind pixel_mux_mode_select mux_mode_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ctrl_wdata_i(ctrl_wdata_i), .mux2_wr_i(mux2_wr_i), .clk_sel_wr_i(clk_sel_wr_i),
    .pixel_load_clock_i(pixel_load_clock_i), .load_ready_o(load_ready_o), .load_lost_o(load_lost_o),
    .pix_o(pix_o), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i), .mode_o(mode_o),
    .mux1_code_o(mux1_code_o), .mux2_code_o(mux2_code_o), .vga_port_en_o(vga_port_en_o),
    .refclk_div_o(refclk_div_o));
